// *** shared/trpo_pkg.sv ***
package trpo_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // pixel and entry layout
  localparam int unsigned COLOR_W   = 8;
  localparam int unsigned PIX_W     = 3 * COLOR_W;
  localparam int unsigned CTL_W     = 5;
  localparam int unsigned BUF_WIDTH = 1 + CTL_W + 2 * PIX_W;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned EVEN_LSB  = 0;
  localparam int unsigned ODD_LSB   = PIX_W;
  localparam int unsigned CTL_LSB   = 2 * PIX_W;
  localparam int unsigned DE_POS    = 2 * PIX_W + CTL_W;
  localparam int unsigned SYNC_W    = 1 + 1 + PIX_W + CTL_W + 4;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned CLK_PERIOD_NS   = 25;
  localparam int unsigned OUTPUT_PIXEL_CLOCK_HALF_NS    = 50;
  localparam int unsigned OUTPUT_PIXEL_CLOCK_HALF_CYC   = (OUTPUT_PIXEL_CLOCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STAGGER_SELECT_N_DELAY_NS   = 25;
  localparam int unsigned STAGGER_SELECT_N_RAW_CYC    = STAGGER_SELECT_N_DELAY_NS / CLK_PERIOD_NS;
  localparam int unsigned STAGGER_SELECT_N_CYC        = (STAGGER_SELECT_N_RAW_CYC < 1) ? 1 : STAGGER_SELECT_N_RAW_CYC;
  localparam int unsigned IDLE_TIMEOUT_US = 1000;
  localparam int unsigned IDLE_TIMEOUT_CYC = IDLE_TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int unsigned PH_W            = 2;
  localparam int unsigned IDLE_W          = 16;
  localparam logic [PH_W-1:0] HALF_LAST   = PH_W'(OUTPUT_PIXEL_CLOCK_HALF_CYC - 1);
  localparam logic [PH_W-1:0] STAGGER_SELECT_N_LAST   = PH_W'(STAGGER_SELECT_N_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam logic            RST_CLK_LEVEL = 1'b0;
  localparam logic            RST_ACTIVE    = 1'b0;
  localparam logic [PH_W-1:0] RST_PHASE_CNT = 2'h0;

  typedef enum logic [1:0] {
    OS_IDLE   = 2'b00,
    OS_LAUNCH = 2'b01,
    OS_LATCH  = 2'b11
  } trpo_ostate_t;

endpackage

// *** rtl/trpo_pair_buf.sv ***
`timescale 1ns/10ps
`default_nettype none

module trpo_pair_buf
  import trpo_pkg::*;
#(
  parameter int unsigned WIDTH = BUF_WIDTH
) (
  input  wire logic             i_clock,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic [WIDTH-1:0]      o_out_data
);

  logic [WIDTH-1:0] slot_r [BUF_DEPTH];
  logic [WIDTH-1:0] slot_nxt [BUF_DEPTH];
  logic             wr_r, wr_nxt, rd_r, rd_nxt;
  logic [1:0]       cnt_r, cnt_nxt;
  logic             do_wr, do_rd;

  assign o_in_ready  = (cnt_r != 2'h2);
  assign o_out_valid = (cnt_r != 2'h0);
  assign o_out_data  = slot_r[rd_r];
  assign do_wr       = i_in_valid && o_in_ready;
  assign do_rd       = o_out_valid && i_out_ready;

  always_comb begin
    slot_nxt = slot_r;
    wr_nxt   = wr_r;
    rd_nxt   = rd_r;
    cnt_nxt  = cnt_r;
    if (do_wr) begin
      slot_nxt[wr_r] = i_in_data;
      wr_nxt         = ~wr_r;
    end
    if (do_rd) begin
      rd_nxt = ~rd_r;
    end
    if (do_wr && !do_rd) begin
      cnt_nxt = cnt_r + 2'h1;
    end else if (do_rd && !do_wr) begin
      cnt_nxt = cnt_r - 2'h1;
    end
  end

  always_ff @(posedge i_clock) begin
    slot_r <= slot_nxt;
    if (i_sys_rst) begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      wr_r  <= wr_nxt;
      rd_r  <= rd_nxt;
      cnt_r <= cnt_nxt;
    end
  end

endmodule // trpo_pair_buf

`default_nettype wire

// *** rtl/trpo_pixel_out.sv ***
`timescale 1ns/10ps
`default_nettype none

module trpo_pixel_out
  import trpo_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = IDLE_TIMEOUT_CYC
) (
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  input  wire logic               i_link_clock,
  input  wire logic               i_link_de,
  input  wire logic [COLOR_W-1:0] i_ch0_data,
  input  wire logic [1:0]         i_ch0_ctl,
  input  wire logic [COLOR_W-1:0] i_ch1_data,
  input  wire logic               i_ch1_ctl,
  input  wire logic [COLOR_W-1:0] i_ch2_data,
  input  wire logic [1:0]         i_ch2_ctl,
  input  wire logic               i_pixels_per_clock_select,
  input  wire logic               i_stagger_select_n,
  input  wire logic               i_output_clock_edge_select,
  input  wire logic               i_output_driver_powerdown_n,
  input  wire logic               i_out_ready,
  output logic                    o_output_pixel_clock,
  output logic [PIX_W-1:0]        o_even_pixel_bus,
  output logic [PIX_W-1:0]        o_odd_pixel_bus,
  output logic                    o_de,
  output logic                    o_hsync,
  output logic                    o_vsync,
  output logic                    o_ctl1,
  output logic                    o_ctl2,
  output logic                    o_ctl3,
  output logic                    o_link_active_flag,
  output logic                    o_drv_oe,
  output logic                    o_ctl1_oe,
  output logic                    o_buf_overrun
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: every outside input except i_out_ready and reset passes two flops
  logic [SYNC_W-1:0]  sync1_r, sync2_r;
  logic               lk_s, de_s, dual_s, stagger_select_n_n_s, edge_s, pdn_s;
  logic [COLOR_W-1:0] ch0_s, ch1_s, ch2_s;
  logic [1:0]         ch0c_s, ch2c_s;
  logic               ch1c_s;

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {i_output_driver_powerdown_n, i_output_clock_edge_select, i_stagger_select_n,
                  i_pixels_per_clock_select, i_ch2_ctl, i_ch1_ctl, i_ch0_ctl, i_ch2_data,
                  i_ch1_data, i_ch0_data, i_link_de, i_link_clock};
      sync2_r <= sync1_r;
    end
  end

  assign {pdn_s, edge_s, stagger_select_n_n_s, dual_s, ch2c_s, ch1c_s, ch0c_s, ch2_s, ch1_s, ch0_s,
          de_s, lk_s} = sync2_r;

  ////////////////////////////////////////////////////////////////////////////
  // capture on link clock rising edge, pair pixels in dual mode
  // data must hold at least three system clocks around the link edge
  logic                 lk_d_r, de_prev_r, de_prev_nxt, phase_r, phase_nxt;
  logic [PIX_W-1:0]     even_hold_r, even_hold_nxt, pix;
  logic [CTL_W-1:0]     ctl_hold_r, ctl_hold_nxt, ctl_cur;
  logic                 lk_rise, line_start, de_edge, push, in_ready;
  logic [BUF_WIDTH-1:0] push_data;

  assign lk_rise    = lk_s && !lk_d_r;
  assign line_start = de_s && !de_prev_r;
  assign de_edge    = lk_rise && (de_s != de_prev_r);
  assign pix        = de_s ? {ch2_s, ch1_s, ch0_s} : '0;

  always_comb begin
    de_prev_nxt   = de_prev_r;
    phase_nxt     = phase_r;
    even_hold_nxt = even_hold_r;
    ctl_hold_nxt  = ctl_hold_r;
    ctl_cur       = ctl_hold_r;
    push          = 1'b0;
    push_data     = '0;
    if (lk_rise) begin
      de_prev_nxt = de_s;
      if (!de_s) begin
        ctl_cur      = {ch2c_s[1], ch2c_s[0], ch1c_s, ch0c_s[1], ch0c_s[0]};
        ctl_hold_nxt = ctl_cur;
      end
      if (!dual_s) begin
        push      = 1'b1;
        phase_nxt = 1'b0;
        push_data = {de_s, ctl_cur, {PIX_W{1'b0}}, pix};
      end else if (!phase_r || line_start) begin
        even_hold_nxt = pix;
        phase_nxt     = 1'b1;
      end else begin
        push      = 1'b1;
        phase_nxt = 1'b0;
        push_data = {de_s, ctl_cur, pix, even_hold_r};
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      lk_d_r      <= 1'b0;
      de_prev_r   <= 1'b0;
      phase_r     <= 1'b0;
      even_hold_r <= '0;
      ctl_hold_r  <= '0;
    end else begin
      lk_d_r      <= lk_s;
      de_prev_r   <= de_prev_nxt;
      phase_r     <= phase_nxt;
      even_hold_r <= even_hold_nxt;
      ctl_hold_r  <= ctl_hold_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer between link and panel; the link cannot stall,
  // so a refused push is flagged rather than held
  logic                 buf_valid, pop;
  logic [BUF_WIDTH-1:0] buf_data;

  trpo_pair_buf #(
    .WIDTH (BUF_WIDTH)
  ) u_buf (
    .i_clock     (i_clock),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (push),
    .o_in_ready  (in_ready),
    .i_in_data   (push_data),
    .o_out_valid (buf_valid),
    .i_out_ready (pop),
    .o_out_data  (buf_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // output clock and launch sequencer
  trpo_ostate_t     state_r, state_nxt;
  logic [PH_W-1:0]  cnt_r, cnt_nxt;
  logic             clk_r, clk_nxt, de_o_r, de_o_nxt;
  logic [PIX_W-1:0] even_r, even_nxt, odd_r, odd_nxt, pend_r, pend_nxt;
  logic [CTL_W-1:0] ctl_o_r, ctl_o_nxt;
  logic             stagger_select_n_on;

  assign stagger_select_n_on = dual_s && !stagger_select_n_n_s;
  assign pop     = (state_r == OS_IDLE) && buf_valid && i_out_ready;

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    clk_nxt   = clk_r;
    de_o_nxt  = de_o_r;
    even_nxt  = even_r;
    odd_nxt   = odd_r;
    pend_nxt  = pend_r;
    ctl_o_nxt = ctl_o_r;
    unique case (state_r)
      OS_IDLE: begin
        clk_nxt = edge_s;
        if (pop) begin
          state_nxt = OS_LAUNCH;
          cnt_nxt   = '0;
          clk_nxt   = !edge_s;
          even_nxt  = buf_data[EVEN_LSB +: PIX_W];
          de_o_nxt  = buf_data[DE_POS];
          ctl_o_nxt = buf_data[CTL_LSB +: CTL_W];
          pend_nxt  = dual_s ? buf_data[ODD_LSB +: PIX_W] : '0;
          if (!stagger_select_n_on) begin
            odd_nxt = dual_s ? buf_data[ODD_LSB +: PIX_W] : '0;
          end
        end
      end
      OS_LAUNCH: begin
        cnt_nxt = cnt_r + 2'h1;
        if (stagger_select_n_on && cnt_r == STAGGER_SELECT_N_LAST) begin
          odd_nxt = pend_r;
        end
        if (cnt_r == HALF_LAST) begin
          state_nxt = OS_LATCH;
          cnt_nxt   = '0;
          clk_nxt   = edge_s;
        end
      end
      OS_LATCH: begin
        cnt_nxt = cnt_r + 2'h1;
        if (cnt_r == HALF_LAST) begin
          state_nxt = OS_IDLE;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = OS_IDLE;
        cnt_nxt   = '0;
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      state_r <= OS_IDLE;
      cnt_r   <= RST_PHASE_CNT;
      clk_r   <= RST_CLK_LEVEL;
      de_o_r  <= 1'b0;
      even_r  <= '0;
      odd_r   <= '0;
      pend_r  <= '0;
      ctl_o_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      clk_r   <= clk_nxt;
      de_o_r  <= de_o_nxt;
      even_r  <= even_nxt;
      odd_r   <= odd_nxt;
      pend_r  <= pend_nxt;
      ctl_o_r <= ctl_o_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link activity, driver enables, overrun
  logic [IDLE_W-1:0] idle_r, idle_nxt;
  logic              active_r, active_nxt, oe_r, ovr_r, ctl1_oe_r;

  always_comb begin
    idle_nxt   = idle_r;
    active_nxt = active_r;
    if (de_edge) begin
      idle_nxt   = '0;
      active_nxt = 1'b1;
    end else if (idle_r == IDLE_W'(IDLE_LIMIT - 1)) begin
      active_nxt = 1'b0;
    end else begin
      idle_nxt = idle_r + 16'h0001;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_sys_rst) begin
      idle_r   <= '0;
      active_r <= RST_ACTIVE;
      oe_r      <= 1'b0;
      ovr_r     <= 1'b0;
      ctl1_oe_r <= 1'b0;
    end else begin
      idle_r   <= idle_nxt;
      active_r <= active_nxt;
      oe_r     <= pdn_s;
      ovr_r    <= push && !in_ready;
      // ctl1 ignores powerdown, only reset takes it off the pin
      ctl1_oe_r <= 1'b1;
    end
  end

  assign o_output_pixel_clock = clk_r;
  assign o_even_pixel_bus     = even_r;
  assign o_odd_pixel_bus      = odd_r;
  assign o_de                 = de_o_r;
  assign {o_ctl3, o_ctl2, o_ctl1, o_vsync, o_hsync} = ctl_o_r;
  assign o_link_active_flag   = active_r;
  assign o_drv_oe             = oe_r;
  assign o_ctl1_oe            = ctl1_oe_r;
  assign o_buf_overrun        = ovr_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);

  property p_single_odd_low;
    pop && !dual_s |=> (o_odd_pixel_bus == '0);
  endproperty
  a_single_odd_low: assert property (p_single_odd_low) else $error("odd bus not low");

  property p_even_blue;
    pop |=> (o_even_pixel_bus[COLOR_W-1:0] == $past(buf_data[COLOR_W-1:0]));
  endproperty
  a_even_blue: assert property (p_even_blue) else $error("even blue mismatch");

  property p_ctl_launch;
    pop |=> (ctl_o_r == $past(buf_data[CTL_LSB +: CTL_W])) && (o_de == $past(buf_data[DE_POS]));
  endproperty
  a_ctl_launch: assert property (p_ctl_launch) else $error("control launch wrong");

  property p_blank_ctl;
    lk_rise && !de_s |=> (ctl_hold_r[1:0] == $past(ch0c_s)) && (ctl_hold_r[2] == $past(ch1c_s))
      && (ctl_hold_r[4:3] == $past(ch2c_s));
  endproperty
  a_blank_ctl: assert property (p_blank_ctl) else $error("blank control not taken");

  property p_active_on_de;
    de_edge |=> o_link_active_flag;
  endproperty
  a_active_on_de: assert property (p_active_on_de) else $error("flag not raised");

  property p_active_timeout;
    !de_edge && (idle_r == IDLE_W'(IDLE_LIMIT - 1)) |=> !o_link_active_flag;
  endproperty
  a_active_timeout: assert property (p_active_timeout) else $error("flag not dropped");

  property p_stagger;
    pop && dual_s && !stagger_select_n_n_s |=> $stable(o_odd_pixel_bus) ##1
      (o_odd_pixel_bus == $past(buf_data[ODD_LSB +: PIX_W], 2));
  endproperty
  a_stagger: assert property (p_stagger) else $error("stagger offset wrong");

  property p_no_stagger;
    pop && dual_s && stagger_select_n_n_s |=> (o_odd_pixel_bus == $past(buf_data[ODD_LSB +: PIX_W]));
  endproperty
  a_no_stagger: assert property (p_no_stagger) else $error("odd bus late");

  property p_clock_edge;
    pop && $stable(edge_s) [*1] ##0 (1'b1) |=> (o_output_pixel_clock != edge_s) ##1
      (o_output_pixel_clock != edge_s) ##1 (o_output_pixel_clock == edge_s);
  endproperty
  a_clock_edge: assert property (p_clock_edge) else $error("latch edge wrong");

  property p_powerdown;
    !pdn_s |=> !o_drv_oe ##0 o_ctl1_oe;
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("drivers not off");

  c_single: cover property (pop && !dual_s);
  c_dual_stagger_select_n: cover property (pop && stagger_select_n_on);
  c_link_drop: cover property ($fell(o_link_active_flag));
  c_overrun: cover property (o_buf_overrun);

endmodule // trpo_pixel_out

`default_nettype wire

// *** tb/trpo_link_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module trpo_link_model
  import trpo_pkg::*;
(
  output logic               o_link_clock,
  output logic               o_link_de,
  output logic [COLOR_W-1:0] o_ch0_data,
  output logic [1:0]         o_ch0_ctl,
  output logic [COLOR_W-1:0] o_ch1_data,
  output logic               o_ch1_ctl,
  output logic [COLOR_W-1:0] o_ch2_data,
  output logic [1:0]         o_ch2_ctl
);

  initial begin
    o_link_clock = 1'b0;
    o_link_de    = 1'b0;
    o_ch0_data   = 8'h00;
    o_ch0_ctl    = 2'h0;
    o_ch1_data   = 8'h00;
    o_ch1_ctl    = 1'b0;
    o_ch2_data   = 8'h00;
    o_ch2_ctl    = 2'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one word per 200 ns period; offset 3 ns so rises never meet the fast clock
  task automatic send(input logic de, input logic [PIX_W-1:0] pix, input logic [CTL_W-1:0] ctl);
    o_link_de  <= de;
    o_ch0_data <= pix[7:0];
    o_ch0_ctl  <= ctl[1:0];
    o_ch1_data <= pix[15:8];
    o_ch1_ctl  <= ctl[2];
    o_ch2_data <= pix[23:16];
    o_ch2_ctl  <= ctl[4:3];
    #103 o_link_clock <= 1'b1;
    #97 o_link_clock <= 1'b0;
  endtask

  // clock stands still between frames, released lines show the inverse
  task automatic idle();
    o_link_de  <= ~o_link_de;
    o_ch0_data <= ~o_ch0_data;
    o_ch0_ctl  <= ~o_ch0_ctl;
    o_ch1_data <= ~o_ch1_data;
    o_ch1_ctl  <= ~o_ch1_ctl;
    o_ch2_data <= ~o_ch2_data;
    o_ch2_ctl  <= ~o_ch2_ctl;
  endtask

endmodule // trpo_link_model

`default_nettype wire

// *** tb/tmds_receiver_pixel_output_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module tmds_receiver_pixel_output_test
  import trpo_pkg::*;
;
  logic i_clock, i_sys_rst, pix_sel, stagger_select_n_n, edge_sel, pd_n, out_rdy, fb_mode, prev_ck, ev_chg_d;
  wire              link_ck, link_de, c1;
  wire [7:0]        ch0, ch1, ch2;
  wire [1:0]        c0, c2;
  logic             ock, de, hs, vs, k1, k2, k3, flag, drv_oe, ctl1_oe, ovr;
  logic [PIX_W-1:0] ev, od, prev_ev, prev_od, even_hold;
  logic [CTL_W-1:0] ctl_hold;
  logic             odd_next;
  logic [53:0]      got_q[$];
  logic [53:0]      exp_q[$];
  int               same_n, lag_n, ovr_n, num_errors, tests_run;

  trpo_link_model LINK (.o_link_clock(link_ck), .o_link_de(link_de), .o_ch0_data(ch0),
    .o_ch0_ctl(c0), .o_ch1_data(ch1), .o_ch1_ctl(c1), .o_ch2_data(ch2), .o_ch2_ctl(c2));

  trpo_pixel_out #(.IDLE_LIMIT(64)) DUT (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
    .i_link_clock(link_ck), .i_link_de(link_de), .i_ch0_data(ch0), .i_ch0_ctl(c0),
    .i_ch1_data(ch1), .i_ch1_ctl(c1), .i_ch2_data(ch2), .i_ch2_ctl(c2),
    .i_pixels_per_clock_select(pix_sel), .i_stagger_select_n(stagger_select_n_n),
    .i_output_clock_edge_select(edge_sel), .i_output_driver_powerdown_n(pd_n),
    .i_out_ready(out_rdy), .o_output_pixel_clock(ock), .o_even_pixel_bus(ev),
    .o_odd_pixel_bus(od), .o_de(de), .o_hsync(hs), .o_vsync(vs), .o_ctl1(k1), .o_ctl2(k2),
    .o_ctl3(k3), .o_link_active_flag(flag), .o_drv_oe(drv_oe), .o_ctl1_oe(ctl1_oe),
    .o_buf_overrun(ovr));

  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture at each move of the output clock to its latching level
  always @(posedge i_clock) begin
    prev_ck  <= ock;
    prev_ev  <= ev;
    prev_od  <= od;
    ev_chg_d <= (ev !== prev_ev);
    if (fb_mode === 1'b1) pd_n <= flag;
    if (ock !== prev_ck && ock === edge_sel) got_q.push_back({de, k3, k2, k1, vs, hs, ev, od});
    if (ev !== prev_ev && od !== prev_od) same_n++;
    if (od !== prev_od && ev === prev_ev && ev_chg_d === 1'b1) lag_n++;
    if (ovr === 1'b1) ovr_n++;
  end

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // expectation built from the word sent; lost words leave no trace
  task automatic xfer(input logic d, input logic [PIX_W-1:0] pix, input logic [CTL_W-1:0] ctl,
                      input bit lost = 1'b0);
    LINK.send(d, pix, ctl);
    if (lost) return;
    if (!d) ctl_hold = ctl;
    if (!pix_sel) exp_q.push_back({d, ctl_hold, d ? pix : 24'h0, 24'h0});
    else if (!odd_next) even_hold = d ? pix : 24'h0;
    else exp_q.push_back({d, ctl_hold, even_hold, d ? pix : 24'h0});
    if (pix_sel) odd_next = !odd_next;
  endtask

  task automatic frame(input int na, input logic [CTL_W-1:0] ctl, input logic [7:0] s);
    for (int i = 0; i < 2; i++) xfer(1'b0, {3{s}}, ctl);
    for (int i = 0; i < na; i++) xfer(1'b1, {s ^ 8'(i), ~8'(i), s + 8'(i)}, ctl);
    LINK.idle();
    repeat (40) @(posedge i_clock);
  endtask

  task automatic compare(input string name);
    check({name, " count"}, 64'(got_q.size()), 64'(exp_q.size()));
    foreach (exp_q[i]) if (i < got_q.size()) check(name, got_q[i], exp_q[i]);
    $display("test %s done", name);
  endtask

  task automatic start(input logic ps, input logic sn, input logic es, input int n);
    i_sys_rst <= 1'b1;
    pix_sel   <= ps;
    stagger_select_n_n    <= sn;
    edge_sel  <= es;
    out_rdy   <= 1'b1;
    repeat (n) @(posedge i_clock);
    check("ctl1 oe in reset", ctl1_oe, 1'b0);
    i_sys_rst <= 1'b0;
    repeat (8) @(posedge i_clock);
    got_q    = {};
    exp_q    = {};
    ctl_hold = 5'h00;
    odd_next = 1'b0;
    same_n   = 0;
    lag_n    = 0;
    ovr_n    = 0;
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    #100us;
    num_errors++;
    final_report();
  end

  initial begin
    {i_sys_rst, pix_sel, stagger_select_n_n, edge_sel, pd_n, out_rdy, fb_mode} = 7'b1011110;
    {prev_ck, ev_chg_d, prev_ev, prev_od} = '0;
    @(posedge i_clock);
    start(1'b0, 1'b1, 1'b1, 12);
    frame(4, 5'h15, 8'h11);
    check("rest level rise", ock, 1'b1);
    compare("single_rise");
    start(1'b0, 1'b1, 1'b0, 4);
    frame(3, 5'h0a, 8'h22);
    check("rest level fall", ock, 1'b0);
    compare("single_fall");
    start(1'b1, 1'b1, 1'b1, 4);
    frame(4, 5'h1f, 8'h33);
    compare("dual");
    check("simultaneous", same_n > 0 && lag_n == 0, 1'b1);
    start(1'b1, 1'b0, 1'b1, 4);
    frame(4, 5'h06, 8'h44);
    compare("dual_stagger");
    check("staggered", lag_n > 0 && same_n == 0, 1'b1);
    // stall: two words held in the buffer, the third is dropped with a pulse
    start(1'b0, 1'b1, 1'b1, 4);
    xfer(1'b0, 24'h0, 5'h03);
    repeat (10) @(posedge i_clock);
    out_rdy <= 1'b0;
    xfer(1'b1, 24'h123456, 5'h03);
    xfer(1'b1, 24'h654321, 5'h03);
    xfer(1'b1, 24'habcdef, 5'h03, 1'b1);
    repeat (10) @(posedge i_clock);
    out_rdy <= 1'b1;
    LINK.idle();
    repeat (40) @(posedge i_clock);
    check("overrun pulses", 64'(ovr_n), 64'd1);
    compare("stall");
    // board ties the flag back to the driver powerdown
    start(1'b0, 1'b1, 1'b1, 4);
    fb_mode <= 1'b1;
    repeat (6) @(posedge i_clock);
    check("flag idle", flag, 1'b0);
    check("drivers off", drv_oe, 1'b0);
    for (int i = 0; i < 6; i++) xfer(i[0], 24'h0, 5'h00);
    check("flag active", flag, 1'b1);
    check("drivers on", drv_oe, 1'b1);
    LINK.idle();
    repeat (100) @(posedge i_clock);
    check("flag lost", flag, 1'b0);
    check("drivers off again", drv_oe, 1'b0);
    check("ctl1 kept", ctl1_oe, 1'b1);
    $display("test activity done");
    final_report();
  end

endmodule // tmds_receiver_pixel_output_test

`default_nettype wire
